// ### mmb_core.sv
/*
 * Management message bridge: PICMG command acceptance, Send Message relay
 * checks, 7-bit serial framing and the persistent port enable status word.
 * Assumes an AHB-Lite master driven by the management firmware, phase and
 * shelf presence levels synchronous to hclk, and an external nonvolatile
 * store that returns the saved word once after reset.
 */
// How it works
// [RL1] Group recognised by netfn 2Ch requests, 2Dh responses
// [RL2] Execute 00,01,04-12,17; others unsupported
// [RL3] Set Port State 0Eh, Get 0Fh implemented
// [RL4] Relay messages between shelf manager and processors
// [RL5] Requester uses netfn 06h, command 34h, tracking
// [RL6] Data 1: tracking 01b plus known channel
// [RL7] Embedded message follows from data byte 2
// [RL8] Relay reply netfn 07h with own completion code
// [RL9] Remote response requester LUN forced to 00b
// [RL10] Serial byte: one marker, seven payload bits
// [RL11] Marker set only on first and last byte
// [RL12] Same framing both encode and decode
// [RL13] Processor unpowered: update word only, ports off
// [RL14] No shelf manager: all point-to-point ports enabled
// [RL15] Boot phase: only replies go to processor
// [RL16] Processor queries port state before changes
// [RL17] Boot phase shelf set raises processor interrupt
// [RL18] OS phase: update word and forward command
// [RL19] Status word saved to nonvolatile store
// [RL20] Status word not reachable over the bus
// [RL21] Word bits: fabric, base, update, clocks, reserved
// [RL22] Unsupported code: invalid completion, no change
// [RL23] Checksum makes byte sum zero
module mmb_core (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [1:0] proc_phase,
  input wire logic shelf_present,
  input wire logic nv_rd_valid,
  input wire logic [mmb_pkg::WORD_W-1:0] nv_rd_word,
  output logic nv_wr_en,
  output logic [mmb_pkg::WORD_W-1:0] nv_wr_word,
  output logic [mmb_pkg::WORD_W-1:0] bp_port_en,
  output logic network_proc_irq,
  output logic fwd_valid,
  output logic [7:0] fwd_cmd,
  output logic [mmb_pkg::WORD_W-1:0] fwd_word,
  input wire logic ser_rx_valid,
  input wire logic [7:0] ser_rx_byte,
  output logic ser_tx_valid,
  output logic [7:0] ser_tx_byte
);

  // ************************************************************
  // Bus slave
  // ************************************************************
  logic wr_pend_r;
  logic [mmb_pkg::ADDR_W-1:0] wr_addr_r;
  logic hreadyout_r;
  logic [31:0] hrdata_r;
  logic addr_phase;

  assign addr_phase = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      hreadyout_r <= 1'b1;
    end else begin
      hreadyout_r <= 1'b1;
      wr_pend_r <= addr_phase && hwrite;
      if (addr_phase && hwrite) begin
        wr_addr_r <= haddr[mmb_pkg::ADDR_W-1:0];
      end
    end
  end

  function automatic logic wr_at(input logic pend, input logic [7:0] a, input logic [7:0] t);
    return pend && (a == t);
  endfunction : wr_at

  logic cmd_go;
  logic arg_wr;
  logic relay_wr;
  logic lun_wr;
  logic ck_wr;
  logic ck_clr;
  logic tx_wr;
  logic rx_ack;
  logic ctrl_wr;
  assign cmd_go = wr_at(wr_pend_r, wr_addr_r, mmb_pkg::A_CMD);
  assign arg_wr = wr_at(wr_pend_r, wr_addr_r, mmb_pkg::A_ARG);
  assign relay_wr = wr_at(wr_pend_r, wr_addr_r, mmb_pkg::A_RELAY);
  assign lun_wr = wr_at(wr_pend_r, wr_addr_r, mmb_pkg::A_LUNFIX);
  assign ck_wr = wr_at(wr_pend_r, wr_addr_r, mmb_pkg::A_CKSUM);
  assign ck_clr = wr_at(wr_pend_r, wr_addr_r, mmb_pkg::A_CKCLR);
  assign tx_wr = wr_at(wr_pend_r, wr_addr_r, mmb_pkg::A_TXCHR);
  assign rx_ack = wr_at(wr_pend_r, wr_addr_r, mmb_pkg::A_RXCHR);
  assign ctrl_wr = wr_at(wr_pend_r, wr_addr_r, mmb_pkg::A_CTRL);

  // ************************************************************
  // Command decode
  // ************************************************************
  function automatic logic grp_supported(input logic [7:0] c);
    return (c == mmb_pkg::CMD_PROPS) || (c == mmb_pkg::CMD_ADDR_INFO) ||
           ((c >= mmb_pkg::CMD_RANGE_LO) && (c <= mmb_pkg::CMD_RANGE_HI)) ||
           (c == mmb_pkg::CMD_BUSED); // RL2 RL3
  endfunction : grp_supported

  logic [7:0] w_code;
  logic [7:0] w_netfn;
  logic w_shelf;
  logic is_grp_req;
  logic is_grp_rsp;
  logic is_relay;
  logic cmd_ok;
  logic port_set;
  logic bus_set;
  logic upd;
  mmb_pkg::mmb_phase_e phase;

  assign w_code = hwdata[7:0];
  assign w_netfn = hwdata[15:8];
  assign w_shelf = hwdata[16];
  assign phase = mmb_pkg::mmb_phase_e'(proc_phase);
  assign is_grp_req = (w_netfn == mmb_pkg::NF_PICMG_REQ); // RL1
  assign is_grp_rsp = (w_netfn == mmb_pkg::NF_PICMG_RSP); // RL1
  assign is_relay = (w_netfn == mmb_pkg::NF_APP_REQ) && (w_code == mmb_pkg::CMD_SEND_MSG); // RL5
  assign cmd_ok = (is_grp_req && grp_supported(w_code)) || is_grp_rsp || is_relay; // RL22
  assign port_set = is_grp_req && (w_code == mmb_pkg::CMD_SET_PORT); // RL3
  assign bus_set = is_grp_req && (w_code == mmb_pkg::CMD_BUSED);
  assign upd = cmd_go && (port_set || bus_set);

  logic [mmb_pkg::WORD_W-1:0] arg_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arg_r <= '0;
    end else if (arg_wr) begin
      arg_r <= hwdata[mmb_pkg::WORD_W-1:0];
    end
  end

  // ************************************************************
  // Port enable status word
  // ************************************************************
  // Only the store, the command path and shelf absence touch the word;
  // the bus has no address that reads or writes it directly.
  logic [mmb_pkg::WORD_W-1:0] word_r;
  logic [mmb_pkg::WORD_W-1:0] word_nxt;

  always_comb begin
    word_nxt = word_r;
    if (nv_rd_valid) begin
      word_nxt = nv_rd_word; // RL19
    end else if (upd && port_set) begin
      word_nxt[mmb_pkg::P2P_HI:mmb_pkg::P2P_LO] = arg_r[mmb_pkg::P2P_HI:mmb_pkg::P2P_LO]; // RL13
    end else if (upd && bus_set) begin
      word_nxt[mmb_pkg::CLKG_HI:mmb_pkg::CLKG_LO] = arg_r[mmb_pkg::CLKG_HI:mmb_pkg::CLKG_LO];
    end
    if (!shelf_present) begin
      word_nxt[mmb_pkg::P2P_HI:mmb_pkg::P2P_LO] = '1; // RL14
    end
    word_nxt[mmb_pkg::WORD_W-1:mmb_pkg::RSVD_LO] = '0; // RL21
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      word_r <= mmb_pkg::WORD_RST;
    end else begin
      word_r <= word_nxt;
    end
  end

  // Every change except the restore load is written through so an unexpected reset restores it
  logic nv_wr_en_r;
  logic [mmb_pkg::WORD_W-1:0] nv_wr_word_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nv_wr_en_r <= 1'b0;
      nv_wr_word_r <= mmb_pkg::WORD_RST;
    end else begin
      nv_wr_en_r <= (word_nxt != word_r) && !nv_rd_valid; // RL19
      nv_wr_word_r <= word_nxt;
    end
  end

  logic [mmb_pkg::WORD_W-1:0] bp_port_en_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bp_port_en_r <= '0;
    end else if (phase == mmb_pkg::PH_UNPOWERED) begin
      bp_port_en_r <= '0; // RL13
    end else begin
      bp_port_en_r <= word_r;
    end
  end

  // ************************************************************
  // Notification of the network processor
  // ************************************************************
  logic network_proc_irq_r;
  logic fwd_valid_r;
  logic [7:0] fwd_cmd_r;
  logic [mmb_pkg::WORD_W-1:0] fwd_word_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      network_proc_irq_r <= 1'b0;
    end else if (upd && w_shelf && (phase == mmb_pkg::PH_BOOT)) begin
      network_proc_irq_r <= 1'b1; // RL17
    end else if (ctrl_wr && hwdata[0]) begin
      network_proc_irq_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fwd_valid_r <= 1'b0;
      fwd_cmd_r <= '0;
      fwd_word_r <= '0;
    end else begin
      fwd_valid_r <= upd && w_shelf && (phase == mmb_pkg::PH_OS); // RL18
      if (upd) begin
        fwd_cmd_r <= w_code;
        fwd_word_r <= word_nxt;
      end
    end
  end

  // ************************************************************
  // Command result
  // ************************************************************
  mmb_pkg::mmb_result_s result_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_r <= mmb_pkg::RESULT_RST;
    end else if (cmd_go) begin
      result_r.supported <= cmd_ok;
      result_r.cc <= cmd_ok ? mmb_pkg::CC_OK : mmb_pkg::CC_INVALID; // RL22
      result_r.rsp_netfn <= is_relay ? mmb_pkg::NF_APP_RSP : (w_netfn | 8'h01); // RL8
      result_r.is_relay <= is_relay; // RL4
      result_r.forwarded <= upd && w_shelf && (phase == mmb_pkg::PH_OS);
      result_r.irq_raised <= upd && w_shelf && (phase == mmb_pkg::PH_BOOT);
    end
  end

  // ************************************************************
  // Relay support
  // ************************************************************
  // Firmware writes data byte 1; the embedded message that follows is
  // streamed through the checksum and LUN helpers below.
  function automatic logic chan_known(input logic [3:0] ch);
    return (ch == mmb_pkg::CH_IPMB) || (ch == mmb_pkg::CH_NETPROC) ||
           (ch == mmb_pkg::CH_ADJ_SERIAL) || (ch == mmb_pkg::CH_ADJ_HOST);
  endfunction : chan_known

  logic [3:0] rly_chan_r;
  logic rly_ok_r;
  logic [7:0] lun_r;
  logic [7:0] ck_sum_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rly_chan_r <= '0;
      rly_ok_r <= 1'b0;
    end else if (relay_wr) begin
      rly_chan_r <= hwdata[3:0];
      rly_ok_r <= result_r.is_relay && (hwdata[7:6] == mmb_pkg::TRACK_REQ) &&
                  chan_known(hwdata[3:0]); // RL6 RL7
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lun_r <= '0;
    end else if (lun_wr) begin
      lun_r <= {hwdata[7:2], mmb_pkg::LUN_ZERO}; // RL9
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ck_sum_r <= '0;
    end else if (ck_clr) begin
      ck_sum_r <= '0;
    end else if (ck_wr) begin
      ck_sum_r <= ck_sum_r + hwdata[7:0]; // RL23
    end
  end

  // ************************************************************
  // Serial framing
  // ************************************************************
  logic req_pend_r;
  logic in_pkt_r;
  logic tx_ok;
  logic tx_refused_r;
  logic ser_tx_valid_r;
  mmb_pkg::mmb_chr_s tx_chr_r;
  mmb_pkg::mmb_chr_s rx_chr_r;
  logic rx_valid_r;
  logic rx_end;
  logic tx_last;

  // Boot code cannot take unsolicited traffic, so only a reply to an
  // outstanding request is let through in that phase.
  assign tx_ok = (phase != mmb_pkg::PH_BOOT) || req_pend_r; // RL15
  assign rx_end = ser_rx_valid && ser_rx_byte[mmb_pkg::CHR_MARK] && in_pkt_r;
  assign tx_last = tx_wr && tx_ok && hwdata[9];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ser_tx_valid_r <= 1'b0;
      tx_chr_r <= '0;
    end else begin
      ser_tx_valid_r <= tx_wr && tx_ok;
      if (tx_wr && tx_ok) begin
        tx_chr_r.marker <= hwdata[8] || hwdata[9]; // RL10 RL11
        tx_chr_r.data <= hwdata[6:0]; // RL12
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_refused_r <= 1'b0;
    end else if (tx_wr && !tx_ok) begin
      tx_refused_r <= 1'b1;
    end else if (ctrl_wr && hwdata[1]) begin
      tx_refused_r <= 1'b0;
    end
  end

  // A closing marker from the processor opens one reply; set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_pend_r <= 1'b0;
    end else if (rx_end) begin
      req_pend_r <= 1'b1; // RL15
    end else if (tx_last) begin
      req_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_pkt_r <= 1'b0;
      rx_chr_r <= '0;
    end else if (ser_rx_valid) begin
      rx_chr_r <= mmb_pkg::mmb_chr_s'(ser_rx_byte); // RL12
      if (ser_rx_byte[mmb_pkg::CHR_MARK]) begin
        in_pkt_r <= !in_pkt_r; // RL11
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_valid_r <= 1'b0;
    end else if (ser_rx_valid) begin
      rx_valid_r <= 1'b1;
    end else if (rx_ack) begin
      rx_valid_r <= 1'b0;
    end
  end

  // ************************************************************
  // Read mux
  // ************************************************************
  // No address decodes to the status word
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    logic [31:0] d;
    d = '0;
    case (a)
      mmb_pkg::A_RESULT: d = {12'h000, result_r};
      mmb_pkg::A_RELAY: d = {26'h0000000, rly_ok_r, chan_known(rly_chan_r), rly_chan_r};
      mmb_pkg::A_LUNFIX: d = {24'h000000, lun_r};
      mmb_pkg::A_CKSUM: d = {23'h000000, (ck_sum_r == 8'h00), ck_sum_r};
      mmb_pkg::A_RXCHR: d = {22'h000000, in_pkt_r, rx_valid_r, rx_chr_r};
      mmb_pkg::A_CTRL: d = {26'h0000000, req_pend_r, tx_refused_r, network_proc_irq_r,
                            shelf_present, proc_phase};
      default: d = '0; // RL20
    endcase
    return d;
  endfunction : rd_mux

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= '0;
    end else if (addr_phase && !hwrite) begin
      hrdata_r <= rd_mux(haddr[mmb_pkg::ADDR_W-1:0]);
    end
  end

  assign hreadyout = hreadyout_r;
  assign hrdata = hrdata_r;
  assign hresp = 1'b0;
  assign nv_wr_en = nv_wr_en_r;
  assign nv_wr_word = nv_wr_word_r;
  assign bp_port_en = bp_port_en_r;
  assign network_proc_irq = network_proc_irq_r;
  assign fwd_valid = fwd_valid_r;
  assign fwd_cmd = fwd_cmd_r;
  assign fwd_word = fwd_word_r;
  assign ser_tx_valid = ser_tx_valid_r;
  assign ser_tx_byte = tx_chr_r;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_unsup_no_change: assert property (cmd_go && !cmd_ok && shelf_present && !nv_rd_valid
      |=> (word_r == $past(word_r)) && (result_r.cc == mmb_pkg::CC_INVALID)) // RL22
    else $error("unsupported command changed state");
  a_group_codes: assert property (cmd_go && is_grp_req && (w_code == mmb_pkg::CMD_GET_PORT)
      |=> result_r.supported && (result_r.rsp_netfn == mmb_pkg::NF_PICMG_RSP)) // RL3
    else $error("get port state not accepted");
  a_unpowered_off: assert property ((phase == mmb_pkg::PH_UNPOWERED)
      |=> (bp_port_en_r == '0) && !fwd_valid_r) // RL13
    else $error("ports enabled while processor unpowered");
  a_noshelf_ports: assert property (!shelf_present
      |=> word_r[mmb_pkg::P2P_HI:mmb_pkg::P2P_LO] == 11'h7ff) // RL14
    else $error("ports not enabled without shelf manager");
  a_boot_irq: assert property (upd && w_shelf && (phase == mmb_pkg::PH_BOOT)
      |=> network_proc_irq_r && !fwd_valid_r) // RL17
    else $error("boot phase set did not interrupt");
  a_os_forward: assert property (upd && w_shelf && (phase == mmb_pkg::PH_OS)
      |=> fwd_valid_r && (fwd_cmd_r == $past(w_code)) ##1 !fwd_valid_r) // RL18
    else $error("os phase set not forwarded once");
  a_tx_marker: assert property (tx_wr && tx_ok
      |=> ser_tx_valid_r && (ser_tx_byte[7] == $past(hwdata[8] || hwdata[9]))
          && (ser_tx_byte[6:0] == $past(hwdata[6:0]))) // RL11
    else $error("serial marker or payload wrong");
  a_boot_tx_gate: assert property (tx_wr && (phase == mmb_pkg::PH_BOOT) && !req_pend_r
      |=> !ser_tx_valid_r && tx_refused_r) // RL15
    else $error("unsolicited byte sent in boot phase");
  a_nv_follow: assert property ((word_nxt != word_r) && !nv_rd_valid
      |=> nv_wr_en_r && (nv_wr_word_r == word_r)) // RL19
    else $error("status word change not saved");
  a_lun_clear: assert property (lun_wr
      |=> (lun_r[1:0] == mmb_pkg::LUN_ZERO) && (lun_r[7:2] == $past(hwdata[7:2]))) // RL9
    else $error("requester lun not cleared");
  a_reserved_zero: assert property (word_r[mmb_pkg::WORD_W-1:mmb_pkg::RSVD_LO] == 3'b000) // RL21
    else $error("reserved word bits set");
  a_relay_reply: assert property (cmd_go && is_relay
      |=> (result_r.rsp_netfn == mmb_pkg::NF_APP_RSP) && result_r.is_relay) // RL8
    else $error("relay reply netfn wrong");

  c_boot_irq: cover property (upd && (phase == mmb_pkg::PH_BOOT) ##1 network_proc_irq_r);
  c_os_fwd: cover property (fwd_valid_r);
  c_relay_ok: cover property (relay_wr ##1 rly_ok_r);
  c_rx_reply: cover property (rx_end ##[1:20] tx_last);

endmodule : mmb_core

// ### mmb_nv_model.sv
/*
 * Behavioural nonvolatile store for the bridge's port enable status word.
 * Assumes the bridge's single clock and its one-cycle write pulse.
 */
module mmb_nv_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic nv_wr_en,
  input wire logic [mmb_pkg::WORD_W-1:0] nv_wr_word,
  output logic nv_rd_valid,
  output logic [mmb_pkg::WORD_W-1:0] nv_rd_word
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [mmb_pkg::WORD_W-1:0] store_r = 17'h00000;
  logic done_r;
  // Never reset: the saved word must outlive a bridge reset
  always_ff @(posedge hclk) begin
    if (nv_wr_en)
      store_r <= nv_wr_word;
  end
  // One restore pulse on the first edge after each reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nv_rd_valid <= 1'b0;
      done_r <= 1'b0;
    end else begin
      nv_rd_valid <= !done_r;
      done_r <= 1'b1;
    end
  end
  // Outside the pulse the data lines carry no stale copy
  assign nv_rd_word = nv_rd_valid ? store_r : ~store_r;
endmodule : mmb_nv_model

// ### mmb_pkg.sv
/*
 * Constants, register map and carrier types of the management message
 * bridge. Assumes a single 40 MHz clock and AHB-Lite word accesses.
 */
package mmb_pkg;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_ARG = 8'h04;
  localparam logic [7:0] A_RESULT = 8'h08;
  localparam logic [7:0] A_RELAY = 8'h0c;
  localparam logic [7:0] A_LUNFIX = 8'h10;
  localparam logic [7:0] A_CKSUM = 8'h14;
  localparam logic [7:0] A_CKCLR = 8'h18;
  localparam logic [7:0] A_TXCHR = 8'h1c;
  localparam logic [7:0] A_RXCHR = 8'h20;
  localparam logic [7:0] A_CTRL = 8'h24;
  localparam int ADDR_W = 8;

  // ************************************************************
  // Message codes
  // ************************************************************
  localparam logic [7:0] NF_PICMG_REQ = 8'h2c;
  localparam logic [7:0] NF_PICMG_RSP = 8'h2d;
  localparam logic [7:0] NF_APP_REQ = 8'h06;
  localparam logic [7:0] NF_APP_RSP = 8'h07;
  localparam logic [7:0] CMD_SEND_MSG = 8'h34;
  localparam logic [7:0] CMD_PROPS = 8'h00;
  localparam logic [7:0] CMD_ADDR_INFO = 8'h01;
  localparam logic [7:0] CMD_RANGE_LO = 8'h04;
  localparam logic [7:0] CMD_RANGE_HI = 8'h12;
  localparam logic [7:0] CMD_SET_PORT = 8'h0e;
  localparam logic [7:0] CMD_GET_PORT = 8'h0f;
  localparam logic [7:0] CMD_BUSED = 8'h17;
  localparam logic [7:0] CC_OK = 8'h00;
  localparam logic [7:0] CC_INVALID = 8'hc1;
  localparam logic [1:0] TRACK_REQ = 2'b01;
  localparam logic [3:0] CH_IPMB = 4'h0;
  localparam logic [3:0] CH_NETPROC = 4'h4;
  localparam logic [3:0] CH_ADJ_SERIAL = 4'h5;
  localparam logic [3:0] CH_ADJ_HOST = 4'h6;
  localparam logic [1:0] LUN_ZERO = 2'b00;

  // ************************************************************
  // Port enable status word layout
  // ************************************************************
  localparam int WORD_W = 17;
  localparam int P2P_LO = 0;
  localparam int P2P_HI = 10;
  localparam int CLKG_LO = 11;
  localparam int CLKG_HI = 13;
  localparam int RSVD_LO = 14;
  localparam logic [WORD_W-1:0] WORD_RST = 17'h00000;

  // Network processor phases, as driven on the phase input
  typedef enum logic [1:0] {
    PH_UNPOWERED,
    PH_BOOT,
    PH_OS
  } mmb_phase_e;

  // Serial character: marker in bit 7, payload below
  localparam int CHR_MARK = 7;
  typedef struct packed {
    logic marker;
    logic [6:0] data;
  } mmb_chr_s;

  typedef struct packed {
    logic [7:0] rsp_netfn;
    logic [7:0] cc;
    logic is_relay;
    logic forwarded;
    logic irq_raised;
    logic supported;
  } mmb_result_s;

  localparam mmb_result_s RESULT_RST = '{8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0};

endpackage : mmb_pkg

// ### tb.sv
/*
 * Directed bench for mmb_core: AHB-Lite master tasks and call sequences.
 * Assumes mmb_pkg and mmb_nv_model are compiled before it.
 */
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, shelf_present = 1'b1;
  logic ser_rx_valid = 1'b0, hready, hreadyout, hresp, nv_rd_valid, nv_wr_en, network_proc_irq;
  logic fwd_valid, ser_tx_valid, kn;
  logic [1:0] htrans = 2'b00, proc_phase = mmb_pkg::PH_OS;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [7:0] ser_rx_byte = 8'h00, fwd_cmd, ser_tx_byte;
  logic [mmb_pkg::WORD_W-1:0] nv_rd_word, nv_wr_word, bp_port_en, fwd_word;
  logic [3:0] chs [6] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h2};
  int miscompares = 0;
  int check_count = 0;
  int fwd_n = 0;
  int tx_n = 0;
  int nv_n = 0;
  assign hready = hreadyout;
  mmb_core mmb_core_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hrdata, .hresp, .proc_phase, .shelf_present,
    .nv_rd_valid, .nv_rd_word, .nv_wr_en, .nv_wr_word, .bp_port_en, .network_proc_irq,
    .fwd_valid, .fwd_cmd, .fwd_word, .ser_rx_valid, .ser_rx_byte, .ser_tx_valid,
    .ser_tx_byte);
  mmb_nv_model mmb_nv_model_inst (.hclk, .hresetn, .nv_wr_en, .nv_wr_word,
    .nv_rd_valid, .nv_rd_word);
  initial forever #12.5 hclk = ~hclk;
  // One-cycle pulses are counted here so no sequence has to catch them
  always @(posedge hclk) begin
    fwd_n += int'(fwd_valid === 1'b1);
    tx_n += int'(ser_tx_valid === 1'b1);
    nv_n += int'(nv_wr_en === 1'b1);
  end
  // ************************************************************
  // Bus and check tasks
  // ************************************************************
  task test_done;
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask : chk
  task automatic hwait(inout int n);
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 40);
  endtask : hwait
  // Select stays high; IDLE in the data phase keeps the slave quiet
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge hclk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    hwait(n);
    htrans <= 2'b00;
    hwdata <= d;
    hwait(n);
    rd = hrdata;
    if (n >= 40) begin
      miscompares++;
      test_done();
    end
  endtask : bus
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask : rc
  task automatic cmd(input logic s, input logic [7:0] nf, input logic [7:0] c);
    bus(1'b1, mmb_pkg::A_CMD, {15'h0, s, nf, c});
    bus(1'b0, mmb_pkg::A_RESULT, 32'h0);
  endtask : cmd
  task automatic tx(input logic [31:0] d, input logic [7:0] e);
    bus(1'b1, mmb_pkg::A_TXCHR, d);
    repeat (2) @(posedge hclk);
    chk(ser_tx_byte, e);
  endtask : tx
  task automatic sx(input logic [7:0] b);
    @(posedge hclk);
    ser_rx_valid <= 1'b1;
    ser_rx_byte <= b;
    @(posedge hclk);
    ser_rx_valid <= 1'b0;
  endtask : sx
  // Restore pulse, word load and port copy all land within four edges
  task rst;
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask : rst
  // ************************************************************
  // Sequences
  // ************************************************************
  initial begin
    rst();
    bus(1'b1, mmb_pkg::A_ARG, 32'h5a5);
    cmd(1'b1, mmb_pkg::NF_PICMG_REQ, mmb_pkg::CMD_SET_PORT);
    chk(rd[19:0], 20'h2d005);
    chk(bp_port_en, 17'h005a5);
    chk(fwd_cmd, 8'h0e);
    chk(fwd_word, 17'h005a5);
    chk(fwd_n, 32'h1);
    bus(1'b1, mmb_pkg::A_ARG, 32'h2da5);
    cmd(1'b1, 8'h2c, 8'h17);
    chk(bp_port_en, 17'h02da5);
    for (int c = 0; c < 26; c++) begin
      cmd(1'b0, 8'h2c, 8'(c));
      kn = c < 2 || (c > 3 && c < 19) || c == 23;
      chk(rd[11:0] & 12'hff1, kn ? 12'h001 : 12'hc10);
    end
    chk(bp_port_en, 17'h02da5);
    cmd(1'b1, 8'h30, 8'h0e);
    chk(rd[11:0] & 12'hff1, 12'hc10);
    cmd(1'b1, 8'h2d, 8'h0e);
    chk(rd[19:0], 20'h2d001);
    cmd(1'b0, 8'h06, 8'h34);
    chk({rd[19:12], rd[3]}, 9'h00f);
    foreach (chs[i]) begin
      bus(1'b1, mmb_pkg::A_RELAY, {28'h4, chs[i]});
      kn = chs[i] inside {4'h0, 4'h4, 4'h5, 4'h6};
      rc(mmb_pkg::A_RELAY, 32'h3f, {26'h0, kn, kn, chs[i]});
    end
    bus(1'b1, mmb_pkg::A_RELAY, 32'h04);
    rc(mmb_pkg::A_RELAY, 32'h3f, 32'h14);
    bus(1'b1, mmb_pkg::A_LUNFIX, 32'hb7);
    rc(mmb_pkg::A_LUNFIX, 32'hff, 32'hb4);
    bus(1'b1, mmb_pkg::A_CKCLR, 32'h0);
    bus(1'b1, mmb_pkg::A_CKSUM, 32'h20);
    bus(1'b1, mmb_pkg::A_CKSUM, 32'h18);
    bus(1'b1, mmb_pkg::A_CKSUM, 32'hc8);
    rc(mmb_pkg::A_CKSUM, 32'h1ff, 32'h100);
    bus(1'b1, mmb_pkg::A_CKSUM, 32'h01);
    rc(mmb_pkg::A_CKSUM, 32'h1ff, 32'h001);
    sx(8'h81);
    rc(mmb_pkg::A_RXCHR, 32'h3ff, 32'h381);
    sx(8'h22);
    sx(8'h85);
    rc(mmb_pkg::A_RXCHR, 32'h3ff, 32'h185);
    bus(1'b1, mmb_pkg::A_RXCHR, 32'h0);
    rc(mmb_pkg::A_RXCHR, 32'h3ff, 32'h085);
    tx(32'h17f, 8'hff);
    tx(32'h055, 8'h55);
    tx(32'h203, 8'h83);
    proc_phase <= mmb_pkg::PH_BOOT;
    bus(1'b1, mmb_pkg::A_TXCHR, 32'h201);
    rc(mmb_pkg::A_CTRL, 32'h3f, 32'h15);
    chk(tx_n, 32'h3);
    bus(1'b1, mmb_pkg::A_CTRL, 32'h2);
    sx(8'h81);
    sx(8'h81);
    rc(mmb_pkg::A_CTRL, 32'h3f, 32'h25);
    tx(32'h300, 8'h80);
    rc(mmb_pkg::A_CTRL, 32'h3f, 32'h05);
    cmd(1'b0, 8'h2c, 8'h0f);
    chk(rd[11:0], 12'h001);
    bus(1'b1, mmb_pkg::A_ARG, 32'h7ff);
    cmd(1'b1, 8'h2c, 8'h0e);
    chk(rd[2:0], 3'b011);
    chk(network_proc_irq, 1'b1);
    bus(1'b1, mmb_pkg::A_CTRL, 32'h1);
    rc(mmb_pkg::A_CTRL, 32'h8, 32'h0);
    proc_phase <= mmb_pkg::PH_UNPOWERED;
    bus(1'b1, mmb_pkg::A_ARG, 32'h3ff);
    cmd(1'b1, 8'h2c, 8'h0e);
    chk(rd[2:0], 3'b001);
    chk(bp_port_en, 17'h0);
    proc_phase <= mmb_pkg::PH_OS;
    rst();
    chk(bp_port_en, 17'h02bff);
    shelf_present <= 1'b0;
    repeat (4) @(posedge hclk);
    chk(bp_port_en, 17'h02fff);
    rc(8'h28, 32'hffffffff, 32'h0);
    chk(fwd_n, 32'h2);
    chk(tx_n, 32'h4);
    chk(nv_n, 32'h5);
    chk(hresp, 1'b0);
    test_done();
  end
endmodule : tb
